// >>> rtl/dpmux_ctrl.sv
// control logic of the dual-input power mux and its two gate drives
`timescale 1ns/10ps
`include "dpmux_params.svh"

module dpmux_ctrl (
    // clock, reset and clock enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // drive pins sensed grounded, asynchronous
    input wire logic [1:0] drive_pin_grounded,
    // analog comparators, asynchronous
    input wire dpmux_pkg::dpmux_sense_t sense,
    // host command port, same clock
    input wire logic host_wr,
    input wire dpmux_pkg::dpmux_cmd_t host_cmd,
    // gate drives of the fet pairs
    output logic path1_gate_drive,
    output logic path2_gate_drive,
    // closed status per path
    output logic path1_closed_status,
    output logic path2_closed_status,
    // control fields as they stand
    output logic disable_all_path_drives,
    output logic path1_drive_enable,
    output logic path2_drive_enable,
    output logic input_high_impedance,
    // detection results
    output logic [1:0] pair_fitted,
    output logic detect_done
);

    // reset synchroniser stages
    logic rst_meta_ff;
    logic rst_sync_ff;
    // two-stage synchroniser of the sensed pins and comparators
    logic [1:0] gnd_meta_ff;
    logic [1:0] gnd_sync_ff;
    dpmux_pkg::dpmux_sense_t sense_meta_ff;
    dpmux_pkg::dpmux_sense_t sense_sync_ff;
    // detection sequence
    dpmux_pkg::dpmux_state_t state_ff;
    dpmux_pkg::dpmux_state_t nxt_state;
    logic [`DPMUX_CNT_W-1:0] settle_cnt_ff;
    logic [`DPMUX_CNT_W-1:0] nxt_settle_cnt;
    // fitted pairs, latched once
    logic [1:0] fitted_ff;
    logic done_ff;
    // host visible control fields
    logic dis_ff;
    logic nxt_dis;
    logic [1:0] en_ff;
    logic [1:0] nxt_en;
    logic hiz_ff;
    // previous validity, for rising-edge detection
    logic [1:0] valid_d_ff;
    // per-path qualification and drive
    logic [1:0] valid;
    logic [1:0] qual;
    logic [1:0] drive_ff;
    logic [1:0] stat_ff;
    // rising edge of a valid input per path
    logic [1:0] valid_rise;
    // the enable field of a write of both enables high is refused
    logic both_req;

    // reset release through two flip-flops
    // assertion is immediate, release waits for two clean edges
    // so that no flop leaves reset in a metastable window
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // pins and comparators come from the analog side
    // both stages freeze with the clock enable like all state but the reset synchroniser
    // only the second stage is read, the first may be metastable
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            gnd_meta_ff <= 2'h0;
            gnd_sync_ff <= 2'h0;
            sense_meta_ff <= '0;
            sense_sync_ff <= '0;
        end else if (ce) begin
            gnd_meta_ff <= drive_pin_grounded;
            gnd_sync_ff <= gnd_meta_ff;
            sense_meta_ff <= sense;
            sense_sync_ff <= sense_meta_ff;
        end
    end

    // detection sequence: settle, sample once, then run
    // the pin sense needs time after power-on before it is trusted
    // the sample state takes the pins exactly once per reset
    // later pin changes are ignored until the next power-on
    always_comb begin
        nxt_state = state_ff;
        nxt_settle_cnt = settle_cnt_ff;
        unique case (state_ff)
            dpmux_pkg::DPMUX_SETTLE: begin
                // wait for the pin sense to settle
                if (settle_cnt_ff ==
                    `DPMUX_CNT_W'(`DPMUX_SETTLE_CYC - 1)) begin
                    nxt_state = dpmux_pkg::DPMUX_SAMPLE;
                end else begin
                    nxt_settle_cnt = settle_cnt_ff + `DPMUX_CNT_W'(1);
                end
            end
            dpmux_pkg::DPMUX_SAMPLE: begin
                // pins taken in this cycle
                nxt_state = dpmux_pkg::DPMUX_RUN;
            end
            dpmux_pkg::DPMUX_RUN: begin
                // stays here until the next power-on
                nxt_state = dpmux_pkg::DPMUX_RUN;
            end
        endcase
    end

    // state register of the detection sequence
    // the counter only runs in the settle state
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff <= dpmux_pkg::DPMUX_SETTLE;
            settle_cnt_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
            settle_cnt_ff <= nxt_settle_cnt;
        end
    end

    // a pair is fitted when its drive pin is not grounded, the second only when the first drive pin is not grounded too
    // a grounded drive pin means no fet pair sits behind it
    // the result stays until the next power-on reset
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            fitted_ff <= 2'h0;
            done_ff <= 1'b0;
        end else if (ce) begin
            if (state_ff == dpmux_pkg::DPMUX_SAMPLE) begin
                // second pair only counts with the first present
                fitted_ff[0] <= ~gnd_sync_ff[0];
                fitted_ff[1] <= ~gnd_sync_ff[0] & ~gnd_sync_ff[1];
                done_ff <= 1'b1;
            end
        end
    end

    // the enable field of a write asking both paths on at once is ignored
    // two closed pairs would short the two sources together
    assign both_req = host_cmd.path_drive_enable == 2'h3;

    // disable-all field: host writes, forced on when nothing fitted
    // with no pair present the field is set once and locked
    // host writes before detection ends are ignored
    always_comb begin
        nxt_dis = dis_ff;
        if (state_ff == dpmux_pkg::DPMUX_SAMPLE) begin
            // no pair fitted: force all drives off
            nxt_dis = gnd_sync_ff[0];
        end else if (done_ff && host_wr && fitted_ff[0]) begin
            // field stays set when no pair is present
            nxt_dis = host_cmd.disable_all_path_drives;
        end
    end

    // register of the disable-all field
    // frozen while the clock enable is low
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            dis_ff <= `DPMUX_DIS_RST;
        end else if (ce) begin
            dis_ff <= nxt_dis;
        end
    end

    // high-impedance field: plain host write
    // taken from reset release on, no lock applies
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            hiz_ff <= `DPMUX_HIZ_RST;
        end else if (ce && host_wr) begin
            hiz_ff <= host_cmd.input_high_impedance;
        end
    end

    // input valid: above present threshold and below overvoltage
    assign valid = sense_sync_ff.input_present
                 & ~sense_sync_ff.input_overvoltage;
    assign valid_rise = valid & ~valid_d_ff;

    // previous validity, cleared before detection ends
    // a source present at detection end still counts as new
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            valid_d_ff <= 2'h0;
        end else if (ce && done_ff) begin
            valid_d_ff <= valid;
        end
    end

    // path enables: host writes, locks and automatic set
    // the automatic set only fires on a rising valid input
    // so a source that stays present does not fight the host
    always_comb begin
        nxt_en = en_ff;
        if (!done_ff) begin
            // locked low until detection is over
            nxt_en = 2'h0;
        end else begin
            // host write, refused if both asked at once
            if (host_wr && !both_req) begin
                nxt_en = host_cmd.path_drive_enable;
            end
            // a new valid input claims an idle mux, first wins
            if (valid_rise[0] && !en_ff[1]) begin
                nxt_en = 2'h1;
            end else if (valid_rise[1] && !en_ff[0]
                         && !valid_rise[0]) begin
                nxt_en = 2'h2;
            end
            // writing disable-all high clears the first enable
            // last, so that a new input cannot undo the host swap
            if (host_wr && host_cmd.disable_all_path_drives) begin
                nxt_en[0] = 1'b0;
            end
            // enables of absent pairs stay locked at zero
            nxt_en = nxt_en & fitted_ff;
        end
    end

    // register of the path enables
    // frozen while the clock enable is low
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            en_ff <= `DPMUX_EN_RST;
        end else if (ce) begin
            en_ff <= nxt_en;
        end
    end

    // per-path drive qualification and status
    // qualification uses synchronised sense, so a drive drops
    // three edges after the comparator change and one after the sync
    genvar gi;
    generate
        for (gi = 0; gi < `DPMUX_NPATH; gi++) begin : g_path
            // every turn-on condition at once
            assign qual[gi] = fitted_ff[gi]
                            & valid[gi]
                            & en_ff[gi]
                            & ~dis_ff
                            & ~hiz_ff
                            & ~sense_sync_ff.bus_present;

            // drive and status follow the qualification
            always_ff @(posedge clk or negedge rst_sync_ff) begin
                if (!rst_sync_ff) begin
                    drive_ff[gi] <= 1'b0;
                    stat_ff[gi] <= 1'b0;
                end else if (ce) begin
                    // drops one edge after any condition fails
                    drive_ff[gi] <= qual[gi];
                    // closed while driven, zero when not fitted
                    stat_ff[gi] <= qual[gi];
                end
            end
        end
    endgenerate

    // outputs straight from flip-flops
    // no logic between the registers and the pins
    assign path1_gate_drive = drive_ff[0];
    assign path2_gate_drive = drive_ff[1];
    assign path1_closed_status = stat_ff[0];
    assign path2_closed_status = stat_ff[1];
    assign disable_all_path_drives = dis_ff;
    assign path1_drive_enable = en_ff[0];
    assign path2_drive_enable = en_ff[1];
    assign input_high_impedance = hiz_ff;
    assign pair_fitted = fitted_ff;
    assign detect_done = done_ff;

endmodule : dpmux_ctrl

// >>> rtl/dpmux_params.svh
// constants of the dual-input power mux control block
`ifndef DPMUX_PARAMS_SVH
`define DPMUX_PARAMS_SVH
// core clock period in ns
`define DPMUX_CLK_NS 20
// settle time before the drive pins are sensed, in ns
`define DPMUX_SETTLE_NS 2000
// settle time in cycles, rounded up, at least one
`define DPMUX_SETTLE_CYC \
    ((`DPMUX_SETTLE_NS + `DPMUX_CLK_NS - 1) / `DPMUX_CLK_NS)
// width of the settle counter
`define DPMUX_CNT_W 7
// number of paths
`define DPMUX_NPATH 2
// reset value of the disable-all field
`define DPMUX_DIS_RST 1'b0
// reset value of the path enables
`define DPMUX_EN_RST 2'h0
// reset value of the high-impedance field
`define DPMUX_HIZ_RST 1'b0
`endif

// >>> rtl/dpmux_pkg.sv
// types of the dual-input power mux control block
package dpmux_pkg;
    // host command word, taken on a write strobe
    typedef struct packed {
        logic input_high_impedance;
        logic disable_all_path_drives;
        logic [1:0] path_drive_enable;
    } dpmux_cmd_t;
    // analog comparator outputs, two per path plus bus
    typedef struct packed {
        logic bus_present;
        logic [1:0] input_overvoltage;
        logic [1:0] input_present;
    } dpmux_sense_t;
    // power-on detection sequence
    typedef enum logic [1:0] {
        DPMUX_SETTLE,
        DPMUX_SAMPLE,
        DPMUX_RUN
    } dpmux_state_t;
endpackage : dpmux_pkg

// >>> verification/dpmux_far_model.sv
// far-side model: fet pairs, input sources and their comparators
`timescale 1ns/10ps
module dpmux_far_model (
    // fitting and source levels chosen by the bench
    input wire logic [1:0] fitted,
    input wire logic [1:0] src_on,
    input wire logic [1:0] src_ov,
    input wire logic bus_src_on,
    // views towards the block
    output logic [1:0] drive_pin_grounded,
    output dpmux_pkg::dpmux_sense_t sense
);
    // an absent pair leaves its drive pin tied to ground
    assign drive_pin_grounded = ~fitted;
    // an overvoltage source is still above the present level
    assign sense.input_present = src_on | src_ov;
    assign sense.input_overvoltage = src_ov;
    // bus only rises from the directly tied source
    assign sense.bus_present = bus_src_on;
endmodule : dpmux_far_model

// >>> verification/dpmux_ctrl_sva.sv
// checker of the power mux control ports
`timescale 1ns/10ps
module dpmux_ctrl_chk (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // inputs
    input wire dpmux_pkg::dpmux_sense_t sense,
    input wire logic host_wr,
    input wire dpmux_pkg::dpmux_cmd_t host_cmd,
    // outputs
    input wire logic path1_gate_drive,
    input wire logic path2_gate_drive,
    input wire logic path1_closed_status,
    input wire logic path2_closed_status,
    input wire logic disable_all_path_drives,
    input wire logic path1_drive_enable,
    input wire logic path2_drive_enable,
    input wire logic input_high_impedance,
    input wire logic [1:0] pair_fitted,
    input wire logic detect_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // drive one needs its fields a cycle before
    property p_d1;
        path1_gate_drive |-> $past(path1_drive_enable) && pair_fitted[0] &&
            !$past(disable_all_path_drives) && !$past(input_high_impedance);
    endproperty
    a_d1: assert property (p_d1) else $error("drive one unqualified");
    // drive one needs the comparators three edges before
    property p_d1s;
        path1_gate_drive |-> $past(sense.input_present[0], 3) &&
            !$past(sense.input_overvoltage[0], 3) &&
            !$past(sense.bus_present, 3);
    endproperty
    a_d1s: assert property (p_d1s) else $error("drive one sense");
    // drive two needs pair, enable and its input
    property p_d2;
        path2_gate_drive |-> pair_fitted[1] && $past(path2_drive_enable) &&
            $past(sense.input_present[1], 3) &&
            !$past(sense.input_overvoltage[1], 3);
    endproperty
    a_d2: assert property (p_d2) else $error("drive two unqualified");
    // status mirrors the drive
    property p_st;
        1'b1 |-> path1_closed_status == path1_gate_drive &&
            path2_closed_status == path2_gate_drive;
    endproperty
    a_st: assert property (p_st) else $error("status differs");
    // absent second pair is locked off
    property p_lock;
        detect_done && !pair_fitted[1] |->
            !path2_drive_enable && !path2_closed_status;
    endproperty
    a_lock: assert property (p_lock) else $error("pair two unlocked");
    // nothing fitted forces disable-all
    property p_none;
        detect_done && pair_fitted == 2'h0 |-> disable_all_path_drives &&
            !path1_drive_enable;
    endproperty
    a_none: assert property (p_none) else $error("no pair not locked");
    // disable-all write clears enable one
    property p_dis;
        ce && host_wr && detect_done && pair_fitted[0] &&
            host_cmd.disable_all_path_drives |=> disable_all_path_drives &&
            !path1_drive_enable;
    endproperty
    a_dis: assert property (p_dis) else $error("disable write lost");
    // enable one write taken
    property p_en;
        ce && host_wr && detect_done && pair_fitted[0] &&
            !host_cmd.disable_all_path_drives &&
            host_cmd.path_drive_enable == 2'h1 |=> path1_drive_enable;
    endproperty
    a_en: assert property (p_en) else $error("enable write lost");
    // disable-all or high impedance keeps drives off
    property p_off;
        disable_all_path_drives || input_high_impedance |=>
            !path1_gate_drive && !path2_gate_drive;
    endproperty
    a_off: assert property (p_off) else $error("drive not off");
    c_d1: cover property (path1_gate_drive);
    c_d2: cover property (path2_gate_drive);
    c_none: cover property (detect_done && pair_fitted == 2'h0);
endmodule : dpmux_ctrl_chk
bind dpmux_ctrl dpmux_ctrl_chk i_chk (.clk(clk), .rst_b(rst_b), .ce(ce),
    .sense(sense), .host_wr(host_wr), .host_cmd(host_cmd),
    .path1_gate_drive(path1_gate_drive), .path2_gate_drive(path2_gate_drive),
    .path1_closed_status(path1_closed_status),
    .path2_closed_status(path2_closed_status),
    .disable_all_path_drives(disable_all_path_drives),
    .path1_drive_enable(path1_drive_enable),
    .path2_drive_enable(path2_drive_enable),
    .input_high_impedance(input_high_impedance),
    .pair_fitted(pair_fitted), .detect_done(detect_done));

// >>> verification/testbench.sv
// self-checking bench of the power mux control
`timescale 1ns/10ps
module testbench;
    logic clk, rst_b, ce, host_wr, bus_src_on, done;
    logic d1, d2, s1, s2, dis, en1, en2, hiz;
    logic [1:0] fitted, src_on, src_ov, grounded, fit_seen;
    dpmux_pkg::dpmux_cmd_t host_cmd;
    dpmux_pkg::dpmux_sense_t sense;
    int fail_count, n_tests;
    // far side
    dpmux_far_model i_far (.fitted(fitted), .src_on(src_on), .src_ov(src_ov),
        .bus_src_on(bus_src_on), .drive_pin_grounded(grounded), .sense(sense));
    dpmux_ctrl i_dut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .drive_pin_grounded(grounded), .sense(sense), .host_wr(host_wr),
        .host_cmd(host_cmd), .path1_gate_drive(d1), .path2_gate_drive(d2),
        .path1_closed_status(s1), .path2_closed_status(s2),
        .disable_all_path_drives(dis), .path1_drive_enable(en1),
        .path2_drive_enable(en2), .input_high_impedance(hiz),
        .pair_fitted(fit_seen), .detect_done(done));
    // clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // step n edges, then settle past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // outputs packed {d1,d2,s1,s2,dis,en1,en2,hiz}
    task automatic look(input logic [7:0] exp);
        check("outputs", exp, {d1, d2, s1, s2, dis, en1, en2, hiz});
    endtask : look
    // one host write, then let the drive follow
    task automatic wr(input logic hz, input logic dv, input logic [1:0] en);
        host_cmd = {hz, dv, en};
        host_wr = 1'b1;
        tick(1);
        host_wr = 1'b0;
        tick(3);
    endtask : wr
    // reset with a given fitting, wait for detection
    task automatic power_up(input logic [1:0] fit);
        int k;
        rst_b = 1'b0;
        fitted = fit;
        src_on = 2'h0;
        src_ov = 2'h0;
        bus_src_on = 1'b0;
        tick(10);
        rst_b = 1'b1;
        k = 0;
        while (done !== 1'b1 && k < 300) begin
            tick(1);
            k++;
        end
        check("detect_done", 8'h01, 8'(done));
        check("pair_fitted", 8'(fit & {fit[0], 1'b1}), 8'(fit_seen));
    endtask : power_up
    task automatic test_single();
        power_up(2'h1);
        look(8'h00);
        src_on = 2'h1;
        tick(6);
        look(8'ha4);
        src_ov = 2'h1;
        tick(4);
        look(8'h04);
        src_ov = 2'h0;
        tick(4);
        look(8'ha4);
        wr(1'b1, 1'b0, 2'h1);
        look(8'h05);
        wr(1'b0, 1'b0, 2'h1);
        bus_src_on = 1'b1;
        tick(4);
        look(8'h04);
        bus_src_on = 1'b0;
        tick(4);
        wr(1'b0, 1'b1, 2'h1);
        look(8'h08);
        wr(1'b0, 1'b1, 2'h2);
        look(8'h08);
        wr(1'b0, 1'b0, 2'h1);
        look(8'ha4);
        wr(1'b0, 1'b0, 2'h0);
        look(8'h00);
        wr(1'b0, 1'b0, 2'h3);
        look(8'h00);
        $display("test single_pair done");
    endtask : test_single
    task automatic test_none();
        power_up(2'h0);
        look(8'h08);
        src_on = 2'h3;
        tick(6);
        wr(1'b0, 1'b0, 2'h1);
        look(8'h08);
        $display("test no_pair done");
    endtask : test_none
    task automatic test_dual();
        power_up(2'h3);
        src_on = 2'h2;
        tick(6);
        look(8'h52);
        wr(1'b0, 1'b0, 2'h1);
        look(8'h04);
        src_on = 2'h3;
        tick(6);
        look(8'ha4);
        // clock enable low: a write must not be taken
        ce = 1'b0;
        wr(1'b0, 1'b1, 2'h0);
        look(8'ha4);
        ce = 1'b1;
        $display("test dual_pair done");
    endtask : test_dual
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    // watchdog
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
    initial begin
        fail_count = 0;
        n_tests = 0;
        host_wr = 1'b0;
        host_cmd = 4'h0;
        ce = 1'b1;
        test_single();
        test_none();
        test_dual();
        give_verdict();
    end
endmodule : testbench
